// File: design/sopm_regs.sv
// sopm_regs: system options, part identification and power monitor bank,
// with watchdog timing, conversion trigger routing and clock output.
// assumes a single-cycle register port, analog event inputs from pins,
// and that the chip reset controller drives srst after a reset request.
//
// Summary of operation
// RULE1 - watchdog counts 1 kHz ticks when clock select clear, bus clock when set
// RULE2 - in window mode, 0x55 then 0xAA refreshes only in last quarter
// RULE3 - in window mode, any early reset-status write forces chip reset
// RULE4 - with hw trigger enabled, source bit picks counter overflow or irq pin
// RULE5 - nonzero divider enables clock pin at bus clock over twice divider
// RULE6 - zero divider disables clock output and frees the pin
// RULE7 - write-once bits take only the first write after reset
// RULE8 - read-only identification registers hold part number and revision
// RULE9 - revision field is constant and ignores writes
// RULE10 - low part-number byte in low id register, upper bits in high
// RULE11 - warning flag sets on low supply, also right after reset
// RULE12 - warning flag stays set after condition goes away
// RULE13 - acknowledge clears flag only when condition is gone, stores nothing
// RULE14 - interrupt request follows flag while interrupt enable is set
// RULE15 - detect event forces reset when reset enable and detect enable set
// RULE16 - stop enable keeps detection running in stop mode when set
// RULE17 - detect enable gates detector; when clear other detect bits ignored
// RULE18 - bandgap buffer enable switches reference buffer on or off
// RULE19 - timeout select with clock select picks period; zero disables
// RULE20 - every reset re-arms write-once locks and restores reset values
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "sopm_defs.svh"
module sopm_regs
  import sopm_pkg::*;
#(
  parameter logic [11:0] PART_NUMBER = 12'h5A3, // arbitrary value
  parameter logic [3:0] REVISION = 4'h1, // arbitrary value
  parameter int DIV_W = 3
) (
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // watchdog low-power clock, from a pin
  input wire logic lpo_clk_pin,
  // conversion trigger routing
  input wire logic conv_hw_trigger_enable,
  input wire logic rtc_overflow,
  input wire logic irq_pin,
  output logic conv_trigger,
  // divided clock output
  output logic clock_out_pin,
  output logic clock_out_en,
  // power monitor
  input wire logic low_volt_warn_in,
  input wire logic low_volt_detect_in,
  input wire logic stop_mode,
  output logic low_volt_warn_irq,
  output logic low_volt_detect_active,
  output logic bandgap_buffer_en,
  // reset request to the chip reset controller
  output logic chip_reset_req
);

  // register state
  logic watchdog_clock_select_r;
  logic watchdog_window_mode_r;
  logic conv_trigger_source_select_r;
  logic [DIV_W-1:0] clock_out_divider_r;
  logic [1:0] watchdog_timeout_select_r;
  logic low_volt_warn_flag_r;
  logic low_volt_warn_irq_en_r;
  logic low_volt_reset_en_r;
  logic low_volt_stop_en_r;
  logic low_volt_detect_en_r;
  logic bandgap_buffer_en_r;
  logic opt2_lock_r;
  logic pmc1_lock_r;
  logic wdcfg_lock_r;
  logic [7:0] rdata_r;

  // synchronisers
  logic [1:0] lpo_sync_r;
  logic lpo_last_r;
  logic [1:0] irq_sync_r;
  logic irq_last_r;
  logic [1:0] warn_sync_r;
  logic [1:0] det_sync_r;

  // watchdog
  logic [`SOPM_WD_WIDTH-1:0] wd_cnt_r;
  sopm_svc_e svc_r;
  logic wd_reset_r;
  logic lvd_reset_r;
  logic conv_trigger_r;

  logic wr_opt2;
  logic wr_pmc1;
  logic wr_wdcfg;
  logic wr_rstat;
  logic wd_tick;
  logic wd_enabled;
  logic [`SOPM_WD_WIDTH:0] wd_period;
  logic wd_in_window;
  logic wd_timeout;
  logic svc_done;
  logic detect_live;
  logic warn_live;

  // period in ticks for a timeout select and clock select
  function automatic logic [`SOPM_WD_WIDTH:0] wd_period_of(
    input logic [1:0] tsel,
    input logic clks
  );
    logic [`SOPM_WD_WIDTH:0] one;
    one = {{`SOPM_WD_WIDTH{1'b0}}, 1'b1};
    unique case ({clks, tsel})
      3'b001: wd_period_of = one << `SOPM_LPO_EXP1;
      3'b010: wd_period_of = one << `SOPM_LPO_EXP2;
      3'b011: wd_period_of = one << `SOPM_LPO_EXP3;
      3'b101: wd_period_of = one << `SOPM_BUS_EXP1;
      3'b110: wd_period_of = one << `SOPM_BUS_EXP2;
      3'b111: wd_period_of = one << `SOPM_BUS_EXP3;
      default: wd_period_of = '0;
    endcase
  endfunction : wd_period_of

  assign wr_opt2 = reg_wr && (reg_addr == `SOPM_OFF_OPT2);
  assign wr_pmc1 = reg_wr && (reg_addr == `SOPM_OFF_PMC1);
  assign wr_wdcfg = reg_wr && (reg_addr == `SOPM_OFF_WDCFG);
  assign wr_rstat = reg_wr && (reg_addr == `SOPM_OFF_RSTAT);

  // input synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      lpo_sync_r <= 2'b00;
      lpo_last_r <= 1'b0;
      irq_sync_r <= 2'b00;
      irq_last_r <= 1'b0;
      warn_sync_r <= 2'b00;
      det_sync_r <= 2'b00;
    end else begin
      lpo_sync_r <= {lpo_sync_r[0], lpo_clk_pin};
      lpo_last_r <= lpo_sync_r[1];
      irq_sync_r <= {irq_sync_r[0], irq_pin};
      irq_last_r <= irq_sync_r[1];
      warn_sync_r <= {warn_sync_r[0], low_volt_warn_in};
      det_sync_r <= {det_sync_r[0], low_volt_detect_in};
    end
  end

  // system_options_two: clock select and window are write-once
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_clock_select_r <=
        1'(`SOPM_OPT2_RST >> `SOPM_OPT2_CLKS); // RULE20
      watchdog_window_mode_r <= 1'b0; // RULE20
      opt2_lock_r <= 1'b0; // RULE20
    end else if (wr_opt2 && !opt2_lock_r) begin
      watchdog_clock_select_r <= reg_wdata[`SOPM_OPT2_CLKS]; // RULE7
      watchdog_window_mode_r <= reg_wdata[`SOPM_OPT2_WIN]; // RULE7
      opt2_lock_r <= 1'b1; // RULE7
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conv_trigger_source_select_r <= 1'b0;
      clock_out_divider_r <= '0;
    end else if (wr_opt2) begin
      conv_trigger_source_select_r <= reg_wdata[`SOPM_OPT2_TRGSRC];
      clock_out_divider_r <=
        reg_wdata[`SOPM_OPT2_DIV_LO +: DIV_W];
    end
  end

  // watchdog_config: timeout select, write-once
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_timeout_select_r <= 2'(`SOPM_WDCFG_RST); // RULE20
      wdcfg_lock_r <= 1'b0; // RULE20
    end else if (wr_wdcfg && !wdcfg_lock_r) begin
      watchdog_timeout_select_r <=
        reg_wdata[`SOPM_WDCFG_TSEL_HI:`SOPM_WDCFG_TSEL_LO]; // RULE7
      wdcfg_lock_r <= 1'b1; // RULE7
    end
  end

  // power_monitor_control_one: write-once reset and detect enables
  always_ff @(posedge clk) begin
    if (srst) begin
      low_volt_reset_en_r <=
        1'(`SOPM_PMC1_RST >> `SOPM_PMC1_RSTEN); // RULE20
      low_volt_detect_en_r <=
        1'(`SOPM_PMC1_RST >> `SOPM_PMC1_DETEN); // RULE20
      pmc1_lock_r <= 1'b0; // RULE20
    end else if (wr_pmc1 && !pmc1_lock_r) begin
      low_volt_reset_en_r <= reg_wdata[`SOPM_PMC1_RSTEN]; // RULE7
      low_volt_detect_en_r <= reg_wdata[`SOPM_PMC1_DETEN]; // RULE7
      pmc1_lock_r <= 1'b1; // RULE7
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      low_volt_warn_irq_en_r <= 1'(`SOPM_PMC1_RST >> `SOPM_PMC1_WIE);
      low_volt_stop_en_r <= 1'(`SOPM_PMC1_RST >> `SOPM_PMC1_STOPEN);
      bandgap_buffer_en_r <= 1'(`SOPM_PMC1_RST >> `SOPM_PMC1_BANDGAP_BUFFER_EN);
    end else if (wr_pmc1) begin
      low_volt_warn_irq_en_r <= reg_wdata[`SOPM_PMC1_WIE];
      low_volt_stop_en_r <= reg_wdata[`SOPM_PMC1_STOPEN]; // RULE16
      bandgap_buffer_en_r <= reg_wdata[`SOPM_PMC1_BANDGAP_BUFFER_EN]; // RULE18
    end
  end

  // warning flag: set beats acknowledge
  assign warn_live = warn_sync_r[1];
  always_ff @(posedge clk) begin
    if (srst) begin
      low_volt_warn_flag_r <= 1'b0;
    end else if (warn_live) begin
      low_volt_warn_flag_r <= 1'b1; // RULE11 RULE12
    end else if (wr_pmc1 && reg_wdata[`SOPM_PMC1_WACK]) begin
      low_volt_warn_flag_r <= 1'b0; // RULE13
    end
  end

  // detector gating and detect reset
  assign detect_live = low_volt_detect_en_r &&
    (!stop_mode || low_volt_stop_en_r); // RULE16 RULE17
  always_ff @(posedge clk) begin
    if (srst) begin
      lvd_reset_r <= 1'b0;
    end else begin
      lvd_reset_r <= detect_live && low_volt_reset_en_r &&
        det_sync_r[1]; // RULE15
    end
  end

  // watchdog tick source and period
  assign wd_tick = watchdog_clock_select_r ? 1'b1 :
    (lpo_sync_r[1] && !lpo_last_r); // RULE1
  assign wd_period = wd_period_of(watchdog_timeout_select_r,
    watchdog_clock_select_r); // RULE19
  assign wd_enabled = (watchdog_timeout_select_r != 2'b00); // RULE19
  // window opens after three quarters of the period
  assign wd_in_window = ({1'b0, wd_cnt_r} >=
    (wd_period - (wd_period >> 2))); // RULE2 RULE3
  assign wd_timeout = wd_enabled && wd_tick &&
    ({1'b0, wd_cnt_r} + 19'h0_0001 >= wd_period);
  assign svc_done = wr_rstat && (svc_r == SOPM_SVC_ARMED) &&
    (reg_wdata == `SOPM_SVC_SECOND) &&
    (!watchdog_window_mode_r || wd_in_window); // RULE2

  // service sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      svc_r <= SOPM_SVC_IDLE;
    end else if (wr_rstat) begin
      svc_r <= (reg_wdata == `SOPM_SVC_FIRST) ? SOPM_SVC_ARMED :
        SOPM_SVC_IDLE;
    end
  end

  // watchdog counter
  always_ff @(posedge clk) begin
    if (srst || !wd_enabled || svc_done || wd_timeout) begin
      wd_cnt_r <= '0;
    end else if (wd_tick) begin
      wd_cnt_r <= wd_cnt_r + 18'h0_0001;
    end
  end

  // watchdog reset: timeout or early write in window mode
  always_ff @(posedge clk) begin
    if (srst) begin
      wd_reset_r <= 1'b0;
    end else begin
      wd_reset_r <= wd_timeout || (wd_enabled &&
        watchdog_window_mode_r && wr_rstat && !wd_in_window); // RULE3
    end
  end

  // conversion trigger while rtc_overflow is high, or on rising edge of the irq pin
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_trigger_r <= 1'b0;
    end else begin
      conv_trigger_r <= conv_hw_trigger_enable &&
        (conv_trigger_source_select_r ?
        (irq_sync_r[1] && !irq_last_r) : rtc_overflow); // RULE4
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `SOPM_OFF_OPT2: rdata_r <= {watchdog_clock_select_r,
          watchdog_window_mode_r, 1'b0, conv_trigger_source_select_r,
          1'b0, clock_out_divider_r};
        `SOPM_OFF_IDH: rdata_r <= {REVISION, PART_NUMBER[11:8]}; // RULE8 RULE9
        `SOPM_OFF_IDL: rdata_r <= PART_NUMBER[7:0]; // RULE10
        `SOPM_OFF_PMC1: rdata_r <= {low_volt_warn_flag_r, 1'b0,
          low_volt_warn_irq_en_r, low_volt_reset_en_r,
          low_volt_stop_en_r, low_volt_detect_en_r, 1'b0,
          bandgap_buffer_en_r}; // RULE13
        `SOPM_OFF_WDCFG: rdata_r <= {6'h00, watchdog_timeout_select_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  sopm_clkdiv #(
    .DW(DIV_W)
  ) u_clkdiv (
    .clk(clk),
    .srst(srst),
    .divider(clock_out_divider_r), // RULE5 RULE6
    .clk_out(clock_out_pin),
    .clk_out_en(clock_out_en)
  );

  assign reg_rdata = rdata_r;
  assign conv_trigger = conv_trigger_r;
  assign low_volt_warn_irq = low_volt_warn_flag_r &&
    low_volt_warn_irq_en_r; // RULE14
  assign low_volt_detect_active = detect_live; // RULE17
  assign bandgap_buffer_en = bandgap_buffer_en_r; // RULE18
  assign chip_reset_req = wd_reset_r || lvd_reset_r;

endmodule : sopm_regs

// File: inc/sopm_defs.svh
// sopm_defs.svh: offsets, field positions, reset values and watchdog counts
// for the system options and power monitor register bank.
// assumes an 8-bit register port with byte-wide addresses.
`ifndef SOPM_DEFS_SVH
`define SOPM_DEFS_SVH

// register offsets
`define SOPM_OFF_OPT2 8'h00
`define SOPM_OFF_IDH 8'h01
`define SOPM_OFF_IDL 8'h02
`define SOPM_OFF_PMC1 8'h03
`define SOPM_OFF_WDCFG 8'h04
`define SOPM_OFF_RSTAT 8'h05

// system_options_two fields
`define SOPM_OPT2_CLKS 7
`define SOPM_OPT2_WIN 6
`define SOPM_OPT2_TRGSRC 4
`define SOPM_OPT2_DIV_HI 2
`define SOPM_OPT2_DIV_LO 0
`define SOPM_OPT2_RST 8'h00

// power_monitor_control_one fields
`define SOPM_PMC1_WARNF 7
`define SOPM_PMC1_WACK 6
`define SOPM_PMC1_WIE 5
`define SOPM_PMC1_RSTEN 4
`define SOPM_PMC1_STOPEN 3
`define SOPM_PMC1_DETEN 2
`define SOPM_PMC1_BANDGAP_BUFFER_EN 0
`define SOPM_PMC1_RST 8'h1C

// watchdog_config fields
`define SOPM_WDCFG_TSEL_HI 1
`define SOPM_WDCFG_TSEL_LO 0
`define SOPM_WDCFG_RST 8'h03

// service pair written to the reset status register
`define SOPM_SVC_FIRST 8'h55
`define SOPM_SVC_SECOND 8'hAA

// watchdog period exponents, low-power clock and bus clock
`define SOPM_LPO_EXP1 5
`define SOPM_LPO_EXP2 8
`define SOPM_LPO_EXP3 10
`define SOPM_BUS_EXP1 13
`define SOPM_BUS_EXP2 16
`define SOPM_BUS_EXP3 18
`define SOPM_WD_WIDTH 18

`endif

// File: inc/sopm_pkg.sv
// sopm_pkg: types shared by the system options and power monitor bank.
// assumes sopm_defs.svh is included alongside by the design files.
package sopm_pkg;

  typedef enum logic [0:0] {
    SOPM_SVC_IDLE = 1'b0,
    SOPM_SVC_ARMED = 1'b1
  } sopm_svc_e;

  typedef logic [7:0] sopm_byte_t;

endpackage : sopm_pkg

// File: design/sopm_clkdiv.sv
// sopm_clkdiv: divided bus-clock output, clk / (2 * divider).
// assumes the divider comes from a register on the same clock.
`timescale 1ns/1ps
module sopm_clkdiv #(
  parameter int DW = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [DW-1:0] divider,
  output logic clk_out,
  output logic clk_out_en
);

  logic [DW-1:0] cnt_r;
  logic clk_out_r;

  always_ff @(posedge clk) begin
    if (srst || divider == '0) begin
      cnt_r <= '0;
      clk_out_r <= 1'b0;
    end else if (cnt_r + {{(DW-1){1'b0}}, 1'b1} >= divider) begin
      // half period is divider bus cycles
      cnt_r <= '0;
      clk_out_r <= ~clk_out_r;
    end else begin
      cnt_r <= cnt_r + {{(DW-1){1'b0}}, 1'b1};
    end
  end

  assign clk_out = clk_out_r;
  assign clk_out_en = (divider != '0);

endmodule : sopm_clkdiv

// File: tb/sopm_regs_monitor.sv
// sopm_regs_monitor: port-level checks for the options and power bank.
// assumes one clock clk and synchronous active-high srst.
`timescale 1ns/1ps
module sopm_regs_monitor #(
  parameter logic [11:0] PART_NUMBER = 12'h5a3,
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic lpo_clk_pin,
  input wire logic conv_hw_trigger_enable,
  input wire logic rtc_overflow,
  input wire logic irq_pin,
  input wire logic conv_trigger,
  input wire logic clock_out_pin,
  input wire logic clock_out_en,
  input wire logic low_volt_warn_in,
  input wire logic low_volt_detect_in,
  input wire logic stop_mode,
  input wire logic low_volt_warn_irq,
  input wire logic low_volt_detect_active,
  input wire logic bandgap_buffer_en,
  input wire logic chip_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // cycles since the hw trigger enable went low
  logic [3:0] off_cnt_r;
  always_ff @(posedge clk) begin
    if (srst || conv_hw_trigger_enable) begin
      off_cnt_r <= 4'h0;
    end else if (off_cnt_r != 4'hf) begin
      off_cnt_r <= off_cnt_r + 4'h1;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_id_high: assert property (reg_rd && reg_addr == 8'h01 |=>
    reg_rdata == {REVISION, PART_NUMBER[11:8]})
    else $error("high id register wrong");
  a_id_low: assert property (reg_rd && reg_addr == 8'h02 |=>
    reg_rdata == PART_NUMBER[7:0])
    else $error("low id register wrong");
  a_clkout_off: assert property (!clock_out_en [*2] |-> !clock_out_pin)
    else $error("clock pin moves while disabled");
  a_en_cause: assert property ($changed(clock_out_en) |->
    $past(reg_wr) && $past(reg_addr) == 8'h00)
    else $error("clock enable changed without write");
  a_warn_sticky: assert property (low_volt_warn_irq && !reg_wr |=>
    low_volt_warn_irq)
    else $error("warning request dropped without write");
  a_irq_cause: assert property ($rose(low_volt_warn_irq) |->
    $past(reg_wr) || $past(low_volt_warn_in, 3))
    else $error("warning request without cause");
  a_bg_cause: assert property ($changed(bandgap_buffer_en) |->
    $past(reg_wr) && $past(reg_addr) == 8'h03)
    else $error("bandgap enable changed without write");
  a_trig_cause: assert property (conv_trigger |->
    $past(rtc_overflow) || $past(irq_pin, 3))
    else $error("conversion trigger without source");
  a_trig_off: assert property (off_cnt_r > 4'h5 |-> !conv_trigger)
    else $error("conversion trigger while disabled");
  c_trig: cover property (conv_trigger);
  c_req: cover property (chip_reset_req);
  c_irq: cover property (low_volt_warn_irq);
  c_clk: cover property (clock_out_en ##1 clock_out_pin);
endmodule : sopm_regs_monitor

bind sopm_regs sopm_regs_monitor #(.PART_NUMBER(PART_NUMBER),
  .REVISION(REVISION)) u_mon (.*);

// File: tb/system_options_power_monitor_regs_test.sv
// system_options_power_monitor_regs_test: directed bench for sopm_regs.
// assumes the register map and timings of sopm_regs.
`timescale 1ns/1ps
module system_options_power_monitor_regs_test;
  localparam logic [11:0] PN = 12'h5c7; // arbitrary value
  localparam logic [3:0] RV = 4'h2; // arbitrary value
  logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic lpo_clk_pin = 1'b0, lpo_run = 1'b0, stop_mode = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic conv_hw_trigger_enable = 1'b0, rtc_overflow = 1'b0, irq_pin = 1'b0;
  logic low_volt_warn_in = 1'b0, low_volt_detect_in = 1'b0;
  logic conv_trigger, clock_out_pin, clock_out_en, low_volt_warn_irq;
  logic low_volt_detect_active, bandgap_buffer_en, chip_reset_req;
  logic [2:0] lpo_div = 3'h0;
  int n_errors = 0, tests_run = 0, n;

  sopm_regs #(.PART_NUMBER(PN), .REVISION(RV), .DIV_W(3)) uut (.clk, .srst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lpo_clk_pin,
    .conv_hw_trigger_enable, .rtc_overflow, .irq_pin, .conv_trigger,
    .clock_out_pin, .clock_out_en, .low_volt_warn_in, .low_volt_detect_in,
    .stop_mode, .low_volt_warn_irq, .low_volt_detect_active,
    .bandgap_buffer_en, .chip_reset_req);

  initial forever #4 clk = ~clk;
  // slow watchdog clock, one rising edge every 8 cycles
  always @(posedge clk) if (lpo_run) begin
    lpo_div <= lpo_div + 3'h1;
    lpo_clk_pin <= lpo_div[2];
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bchk(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : bchk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic wait_hi(ref logic s, input int lim, output int k);
    k = 0;
    // let a pulse launched at this edge settle before the first look
    #1;
    while (s !== 1'b1 && k < lim) begin
      @(posedge clk);
      #1 k++;
    end
  endtask : wait_hi
  task automatic run_len(input logic v, output int k);
    k = 0;
    while (clock_out_pin === v && k < 20) begin
      @(posedge clk);
      #1 k++;
    end
  endtask : run_len
  task automatic rst();
    @(posedge clk);
    srst <= 1'b1;
    lpo_run <= 1'b0;
    cyc(20);
    srst <= 1'b0;
  endtask : rst
  task automatic pulse();
    rtc_overflow <= 1'b1;
    cyc(1);
    rtc_overflow <= 1'b0;
  endtask : pulse

  task automatic t_map();
    rst();
    wr(8'h01, 8'hff);
    wr(8'h02, 8'hff);
    rd(8'h00, 8'h00);
    rd(8'h01, {RV, PN[11:8]});
    rd(8'h02, PN[7:0]);
    rd(8'h03, 8'h1c);
    rd(8'h04, 8'h03);
    rd(8'h05, 8'h00);
    rd(8'h40, 8'h00);
  endtask : t_map
  task automatic t_opt2();
    wr(8'h00, 8'hd5);
    wr(8'h00, 8'h13);
    rd(8'h00, 8'hd3);
    bchk(clock_out_en, 1'b1);
    run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk(n[7:0], 8'h03);
    run_len(1'b0, n);
    chk(n[7:0], 8'h03);
    wr(8'h00, 8'hc0);
    cyc(3);
    bchk(clock_out_en, 1'b0);
    bchk(clock_out_pin, 1'b0);
    rst();
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h40);
    wr(8'h05, 8'h55);
    wait_hi(chip_reset_req, 4, n);
    bchk(n < 4, 1'b1);
  endtask : t_opt2
  task automatic t_trig();
    rst();
    conv_hw_trigger_enable <= 1'b1;
    pulse();
    wait_hi(conv_trigger, 4, n);
    bchk(n < 4, 1'b1);
    wr(8'h00, 8'h10);
    pulse();
    wait_hi(conv_trigger, 6, n);
    bchk(n == 6, 1'b1);
    irq_pin <= 1'b1;
    wait_hi(conv_trigger, 8, n);
    bchk(n < 8, 1'b1);
    cyc(2);
    irq_pin <= 1'b0;
    wr(8'h00, 8'h00);
    conv_hw_trigger_enable <= 1'b0;
    cyc(8);
    pulse();
    wait_hi(conv_trigger, 6, n);
    bchk(n == 6, 1'b1);
  endtask : t_trig
  task automatic t_warn();
    low_volt_warn_in <= 1'b1;
    rst();
    cyc(5);
    rd(8'h03, 8'h9c);
    bchk(low_volt_warn_irq, 1'b0);
    wr(8'h03, 8'h7c);
    rd(8'h03, 8'hbc);
    bchk(low_volt_warn_irq, 1'b1);
    low_volt_warn_in <= 1'b0;
    cyc(5);
    rd(8'h03, 8'hbc);
    wr(8'h03, 8'h49);
    rd(8'h03, 8'h1d);
    bchk(low_volt_warn_irq, 1'b0);
    bchk(bandgap_buffer_en, 1'b1);
  endtask : t_warn
  task automatic t_det();
    rst();
    stop_mode <= 1'b1;
    cyc(2);
    bchk(low_volt_detect_active, 1'b1);
    wr(8'h03, 8'h14);
    cyc(1);
    bchk(low_volt_detect_active, 1'b0);
    stop_mode <= 1'b0;
    low_volt_detect_in <= 1'b1;
    wait_hi(chip_reset_req, 6, n);
    bchk(n < 6, 1'b1);
    low_volt_detect_in <= 1'b0;
    rst();
    wr(8'h03, 8'h18);
    cyc(1);
    bchk(low_volt_detect_active, 1'b0);
    low_volt_detect_in <= 1'b1;
    wait_hi(chip_reset_req, 10, n);
    bchk(n == 10, 1'b1);
    low_volt_detect_in <= 1'b0;
  endtask : t_det
  task automatic t_wd();
    rst();
    wr(8'h04, 8'h01);
    lpo_run <= 1'b1;
    wait_hi(chip_reset_req, 400, n);
    bchk(n > 240 && n < 280, 1'b1);
    rst();
    wr(8'h00, 8'h80);
    wr(8'h04, 8'h01);
    wait_hi(chip_reset_req, 9000, n);
    bchk(n > 8180 && n < 8200, 1'b1);
    rst();
    wr(8'h00, 8'h40);
    wr(8'h04, 8'h01);
    lpo_run <= 1'b1;
    cyc(220);
    wr(8'h05, 8'h55);
    wr(8'h05, 8'haa);
    wait_hi(chip_reset_req, 200, n);
    bchk(n == 200, 1'b1);
    rst();
    wr(8'h04, 8'h00);
    lpo_run <= 1'b1;
    wait_hi(chip_reset_req, 300, n);
    bchk(n == 300, 1'b1);
  endtask : t_wd

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    t_map();
    t_opt2();
    t_trig();
    t_warn();
    t_det();
    t_wd();
    stop_test();
  end
endmodule : system_options_power_monitor_regs_test
